/* File: rtl/fsq_sequencer.sv */
// Purpose: flash page erase, byte program and byte read sequencer
// Assumes: CPU stops issuing register accesses while cpu_hold_o is high
// Notes: flash array outputs are levels held for the operation length
//
// How it works
// - boot code modifies app and data zones; app code only data zone
// - boot zone size is a hardware option, disabled up to 4K bytes
// - data zone runs from the low-bound register up to boot start
// - low bound loads from a hardware option or a software write
// - all zones share one 64K byte flash array
// - only page erase, byte program and byte read are offered
// - program only clears bits; erase sets a whole page to ones
// - erase page is 512 bytes with address bits 8..0 zero
// - high and low address registers form the byte address
// - program writes the data register byte into flash
// - read loads the fetched flash byte into the data register
// - mode codes: 03h erase, 02h program, 01h read, 00h standby
// - writes 46h then B9h start an operation; CPU held until done
// - a target beyond the data zone top ignores the trigger
`timescale 1ns/100ps
`include "fsq_defs.svh"
module fsq_sequencer #(
  parameter logic [15:0] READ_TICKS = `FSQ_READ_TICKS,
  parameter logic [15:0] PROG_TICKS = `FSQ_PROG_TICKS,
  parameter logic [15:0] ERASE_TICKS = `FSQ_ERASE_TICKS
) (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire fsq_pkg::fsq_idx_t reg_addr_i,
  input wire fsq_pkg::fsq_byte_t reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output fsq_pkg::fsq_byte_t reg_rdata_o,
  input wire logic cpu_in_boot_i,
  input wire logic [3:0] boot_zone_pages_i,
  input wire fsq_pkg::fsq_byte_t low_bound_opt_i,
  output logic cpu_hold_o,
  output fsq_pkg::fsq_addr_t flash_addr_o,
  output fsq_pkg::fsq_byte_t flash_wdata_o,
  input wire fsq_pkg::fsq_byte_t flash_rdata_i,
  output logic flash_read_o,
  output logic flash_prog_o,
  output logic flash_erase_o
);
  import fsq_pkg::*;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);

  fsq_state_e state_reg;
  fsq_byte_t addr_high_reg;
  fsq_byte_t addr_low_reg;
  fsq_byte_t flash_data_byte_reg;
  fsq_byte_t flash_op_mode_reg;
  fsq_byte_t flash_control_reg;
  fsq_byte_t data_zone_low_bound_reg;
  fsq_byte_t old_byte_reg;
  logic armed_reg;
  logic ignored_reg;
  logic strap_done_reg;
  logic [15:0] op_cnt_reg;
  logic tick;
  logic [3:0] boot_pages;
  logic [16:0] boot_start;
  fsq_addr_t target;
  logic in_range;
  logic modify_ok;
  logic op_ok;
  logic cmd_wr;
  logic fire;
  logic [15:0] limit;
  logic op_last;
  logic read_done;

  assign boot_pages = (boot_zone_pages_i > `FSQ_BOOT_MAX_PAGES) ?
                      `FSQ_BOOT_MAX_PAGES : boot_zone_pages_i;
  // data zone ends below boot start
  assign boot_start = `FSQ_FLASH_TOP -
                      {4'h0, boot_pages, {`FSQ_PAGE_BITS{1'b0}}};
  assign target = {addr_high_reg, addr_low_reg};
  assign in_range = {1'b0, target} < boot_start;
  assign modify_ok = in_range && (cpu_in_boot_i ||
                     {target[15:9], target[8] & ~flash_op_mode_reg[0]} >=
                     data_zone_low_bound_reg);
  always_comb begin
    unique case (flash_op_mode_reg)
      `FSQ_MODE_READ: op_ok = in_range;
      `FSQ_MODE_PROG: op_ok = modify_ok;
      `FSQ_MODE_ERASE: op_ok = modify_ok;
      default: op_ok = 1'b0;
    endcase
    op_ok = op_ok && flash_control_reg[`FSQ_CTRL_EN_BIT];
  end

  assign cmd_wr = reg_wr_i && reg_addr_i == `FSQ_OFS_CMD;
  assign fire = cmd_wr && armed_reg && reg_wdata_i == `FSQ_KEY_SECOND &&
                state_reg == ST_IDLE;

  always_comb begin
    unique case (state_reg)
      ST_PROG: limit = PROG_TICKS;
      ST_ERASE: limit = ERASE_TICKS;
      default: limit = READ_TICKS;
    endcase
  end
  assign op_last = tick && op_cnt_reg == limit - 16'h0001;
  assign read_done = op_last && state_reg == ST_READ;

  fsq_tick_div #(
    .DIV_W(6)
  ) u_tick_div (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .run_i(state_reg != ST_IDLE),
    .div_i(flash_control_reg[`FSQ_CTRL_SEL_MSB:0]),
    .tick_o(tick)
  );

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      armed_reg <= 1'b0;
    end else if (cmd_wr) begin
      armed_reg <= reg_wdata_i == `FSQ_KEY_FIRST;
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      addr_high_reg <= `FSQ_RST_BYTE;
      addr_low_reg <= `FSQ_RST_BYTE;
      flash_op_mode_reg <= `FSQ_RST_BYTE;
      flash_control_reg <= `FSQ_RST_BYTE;
    end else if (reg_wr_i) begin
      unique case (reg_addr_i)
        `FSQ_OFS_ADDR_HIGH: addr_high_reg <= reg_wdata_i;
        `FSQ_OFS_ADDR_LOW: addr_low_reg <= reg_wdata_i;
        `FSQ_OFS_MODE: flash_op_mode_reg <= reg_wdata_i;
        `FSQ_OFS_CTRL: flash_control_reg <= reg_wdata_i & `FSQ_CTRL_MASK;
        default: ;
      endcase
    end
  end

  // low bound from option then software
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      strap_done_reg <= 1'b0;
      data_zone_low_bound_reg <= `FSQ_RST_BYTE;
    end else if (reg_wr_i && reg_addr_i == `FSQ_OFS_LOW_BOUND) begin
      strap_done_reg <= 1'b1;
      data_zone_low_bound_reg <= reg_wdata_i;
    end else if (!strap_done_reg) begin
      strap_done_reg <= 1'b1;
      data_zone_low_bound_reg <= low_bound_opt_i;
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      flash_data_byte_reg <= `FSQ_RST_BYTE;
    end else if (read_done) begin
      flash_data_byte_reg <= flash_rdata_i;
    end else if (reg_wr_i && reg_addr_i == `FSQ_OFS_DATA) begin
      flash_data_byte_reg <= reg_wdata_i;
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ignored_reg <= 1'b0;
    end else if (fire && !op_ok) begin
      ignored_reg <= 1'b1;
    end else if (reg_wr_i && reg_addr_i == `FSQ_OFS_STATUS &&
                 reg_wdata_i[`FSQ_ST_IGN_BIT]) begin
      ignored_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_reg <= ST_IDLE;
      op_cnt_reg <= 16'h0000;
      cpu_hold_o <= 1'b0;
      flash_addr_o <= 16'h0000;
      flash_wdata_o <= `FSQ_RST_BYTE;
      old_byte_reg <= `FSQ_RST_BYTE;
      flash_read_o <= 1'b0;
      flash_prog_o <= 1'b0;
      flash_erase_o <= 1'b0;
    end else begin
      if (tick) begin
        op_cnt_reg <= op_cnt_reg + 16'h0001;
      end
      unique case (state_reg)
        ST_IDLE: begin
          op_cnt_reg <= 16'h0000;
          if (fire && op_ok) begin
            cpu_hold_o <= 1'b1;
            flash_addr_o <= target;
            unique case (flash_op_mode_reg)
              `FSQ_MODE_READ: begin
                state_reg <= ST_READ;
                flash_read_o <= 1'b1;
              end
              `FSQ_MODE_PROG: begin
                state_reg <= ST_OLD;
                flash_read_o <= 1'b1;
              end
              default: begin
                state_reg <= ST_ERASE;
                flash_addr_o <= {target[15:`FSQ_PAGE_BITS],
                                 {`FSQ_PAGE_BITS{1'b0}}};
                flash_erase_o <= 1'b1;
              end
            endcase
          end
        end
        ST_READ: begin
          if (op_last) begin
            state_reg <= ST_IDLE;
            cpu_hold_o <= 1'b0;
            flash_read_o <= 1'b0;
          end
        end
        ST_OLD: begin
          if (op_last) begin
            state_reg <= ST_PROG;
            op_cnt_reg <= 16'h0000;
            old_byte_reg <= flash_rdata_i;
            flash_read_o <= 1'b0;
            flash_prog_o <= 1'b1;
            flash_wdata_o <= flash_rdata_i & flash_data_byte_reg;
          end
        end
        ST_PROG: begin
          if (op_last) begin
            state_reg <= ST_IDLE;
            cpu_hold_o <= 1'b0;
            flash_prog_o <= 1'b0;
          end
        end
        ST_ERASE: begin
          if (op_last) begin
            state_reg <= ST_IDLE;
            cpu_hold_o <= 1'b0;
            flash_erase_o <= 1'b0;
          end
        end
      endcase
    end
  end

  // read port, data valid one cycle after strobe
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reg_rdata_o <= `FSQ_RST_BYTE;
    end else if (!reg_rd_i) begin
      reg_rdata_o <= `FSQ_RST_BYTE;
    end else begin
      unique case (reg_addr_i)
        `FSQ_OFS_ADDR_HIGH: reg_rdata_o <= addr_high_reg;
        `FSQ_OFS_ADDR_LOW: reg_rdata_o <= addr_low_reg;
        `FSQ_OFS_DATA: reg_rdata_o <= flash_data_byte_reg;
        `FSQ_OFS_MODE: reg_rdata_o <= flash_op_mode_reg;
        `FSQ_OFS_CMD: reg_rdata_o <= `FSQ_RST_BYTE;
        `FSQ_OFS_CTRL: reg_rdata_o <= flash_control_reg;
        `FSQ_OFS_LOW_BOUND: reg_rdata_o <= data_zone_low_bound_reg;
        `FSQ_OFS_STATUS: reg_rdata_o <= {5'h00, armed_reg, ignored_reg,
                                         state_reg != ST_IDLE};
      endcase
    end
  end


  chk_erase_page_align: assert property (
    flash_erase_o |-> flash_addr_o[8:0] == 9'h000)
    else $error("erase address not page aligned");
  chk_one_op_only: assert property (
    $onehot0({flash_read_o, flash_prog_o, flash_erase_o}))
    else $error("more than one flash operation at once");
  chk_hold_covers_op: assert property (
    (flash_read_o || flash_prog_o || flash_erase_o) |-> cpu_hold_o)
    else $error("flash busy without cpu hold");
  chk_fire_holds_cpu: assert property (
    fire && op_ok |=> cpu_hold_o && flash_addr_o[15:9] == $past(target[15:9]))
    else $error("accepted trigger did not hold cpu");
  chk_refused_no_op: assert property (
    fire && !op_ok |=> !cpu_hold_o && ignored_reg)
    else $error("refused trigger started an operation");
  chk_standby_no_op: assert property (
    fire && flash_op_mode_reg == `FSQ_MODE_STANDBY |=>
      !cpu_hold_o && $stable(flash_data_byte_reg))
    else $error("standby trigger acted");
  chk_erase_mode_code: assert property (
    fire && op_ok && flash_op_mode_reg == `FSQ_MODE_ERASE |=> flash_erase_o)
    else $error("erase code did not start erase");
  chk_prog_clears_only: assert property (
    $rose(flash_prog_o) |->
      flash_wdata_o == (old_byte_reg & $past(flash_data_byte_reg)))
    else $error("program data would set bits");
  chk_read_loads_data: assert property (
    read_done |=> flash_data_byte_reg == $past(flash_rdata_i) && !cpu_hold_o)
    else $error("read result not loaded");
  chk_app_zone_guard: assert property (
    $rose(flash_prog_o || flash_erase_o) && !cpu_in_boot_i |->
      flash_addr_o[15:8] >= data_zone_low_bound_reg)
    else $error("app code modified outside data zone");
  chk_below_boot: assert property (
    $rose(cpu_hold_o) |-> {1'b0, flash_addr_o} < boot_start)
    else $error("operation inside boot zone");
  chk_boot_max: assert property (
    boot_start >= 17'h0_f000)
    else $error("boot zone larger than 4K");

  cov_erase: cover property ($fell(flash_erase_o));
  cov_prog: cover property ($fell(flash_prog_o));
  cov_read: cover property (read_done);
  cov_refused: cover property (fire && !op_ok);
endmodule : fsq_sequencer

/* File: rtl/fsq_defs.svh */
// Purpose: constants of the flash self-programming sequencer
// Assumes: 8-bit register port, 3-bit register index
// Notes: tick counts are flash timing ticks, not system clocks
`ifndef FSQ_DEFS_SVH
`define FSQ_DEFS_SVH

// register indices
`define FSQ_OFS_ADDR_HIGH 3'h0
`define FSQ_OFS_ADDR_LOW 3'h1
`define FSQ_OFS_DATA 3'h2
`define FSQ_OFS_MODE 3'h3
`define FSQ_OFS_CMD 3'h4
`define FSQ_OFS_CTRL 3'h5
`define FSQ_OFS_LOW_BOUND 3'h6
`define FSQ_OFS_STATUS 3'h7

// control fields
`define FSQ_CTRL_EN_BIT 7
`define FSQ_CTRL_SEL_MSB 5
`define FSQ_CTRL_MASK 8'h0bf

// status fields
`define FSQ_ST_BUSY_BIT 0
`define FSQ_ST_IGN_BIT 1
`define FSQ_ST_ARMED_BIT 2

// reset values
`define FSQ_RST_BYTE 8'h00

// mode codes
`define FSQ_MODE_STANDBY 8'h00
`define FSQ_MODE_READ 8'h01
`define FSQ_MODE_PROG 8'h02
`define FSQ_MODE_ERASE 8'h03

// command key bytes
`define FSQ_KEY_FIRST 8'h46
`define FSQ_KEY_SECOND 8'hb9

// flash geometry
`define FSQ_FLASH_TOP 17'h1_0000
`define FSQ_PAGE_BITS 9
`define FSQ_BOOT_MAX_PAGES 4'h8

// operation lengths in timing ticks
`define FSQ_READ_TICKS 16'h0001
`define FSQ_PROG_TICKS 16'h001e
`define FSQ_ERASE_TICKS 16'h0fa0

`endif

/* File: rtl/fsq_pkg.sv */
// Purpose: types of the flash self-programming sequencer
// Assumes: constants live in fsq_defs.svh
// Notes: none
package fsq_pkg;
  typedef logic [7:0] fsq_byte_t;
  typedef logic [15:0] fsq_addr_t;
  typedef logic [2:0] fsq_idx_t;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_READ,
    ST_OLD,
    ST_PROG,
    ST_ERASE
  } fsq_state_e;
endpackage : fsq_pkg

/* File: rtl/fsq_tick_div.sv */
// Purpose: flash timing tick divider
// Assumes: div_i holds steady while run_i is high
// Notes: one tick every div_i+1 clocks while running
`timescale 1ns/100ps
module fsq_tick_div #(
  parameter int DIV_W = 6
) (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic run_i,
  input wire logic [DIV_W-1:0] div_i,
  output logic tick_o
);
  logic [DIV_W-1:0] cnt_reg;

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_reg <= '0;
      tick_o <= 1'b0;
    end else if (!run_i) begin
      cnt_reg <= '0;
      tick_o <= 1'b0;
    end else if (cnt_reg == div_i) begin
      cnt_reg <= '0;
      tick_o <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + DIV_W'(1);
      tick_o <= 1'b0;
    end
  end
endmodule : fsq_tick_div

/* File: sim/fsq_flash_model.sv */
// Purpose: behavioural flash array behind the sequencer
// Assumes: operation levels stand for a whole phase
// Notes: released read data shows the inverted last byte
`timescale 1ns/100ps
module fsq_flash_model #(
  parameter logic [7:0] INIT = 8'ha5
) (
  input wire logic clock_i,
  input wire fsq_pkg::fsq_addr_t addr_i,
  input wire fsq_pkg::fsq_byte_t wdata_i,
  input wire logic read_i,
  input wire logic prog_i,
  input wire logic erase_i,
  output fsq_pkg::fsq_byte_t rdata_o,
  output logic [7:0] ops_o
);
  import fsq_pkg::*;
  fsq_byte_t mem [0:65535];
  fsq_byte_t last_reg = 8'h00;
  logic [2:0] lvl_reg = 3'h0;
  logic [7:0] ops_reg = 8'h00;
  assign ops_o = ops_reg;
  initial begin
    foreach (mem[i]) mem[i] = INIT;
  end
  always @(posedge clock_i) begin
    lvl_reg <= {read_i, prog_i, erase_i};
    if (lvl_reg == 3'h0 && (read_i | prog_i | erase_i)) begin
      ops_reg <= ops_reg + 8'h01;
    end
    if (prog_i && !lvl_reg[1]) mem[addr_i] <= mem[addr_i] & wdata_i;
    if (erase_i && !lvl_reg[0]) begin
      for (int i = 0; i < 512; i++) mem[{addr_i[15:9], 9'(i)}] <= 8'hff;
    end
    if (read_i) last_reg <= mem[addr_i];
  end
  assign rdata_o = read_i ? mem[addr_i] : ~last_reg;
endmodule : fsq_flash_model

/* File: sim/fsq_sequencer_tb_top.sv */
// Purpose: self-checking bench of the flash sequencer
// Assumes: boot zone of two pages, low bound option 80h
// Notes: short tick counts, flash starts filled with a5h
`timescale 1ns/100ps
`include "fsq_defs.svh"
module fsq_sequencer_tb_top;
  import fsq_pkg::*;
  logic clock_i = 1'b0;
  logic reset_n_i = 1'b0;
  fsq_idx_t reg_addr = 3'h0;
  fsq_byte_t reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic in_boot = 1'b0;
  fsq_byte_t rdata, f_rdata, f_wdata;
  fsq_addr_t f_addr;
  logic hold, f_read, f_prog, f_erase;
  logic [7:0] ops;
  int errors = 0;
  int checked = 0;
  int n0, n3;
  always #12.5 clock_i = ~clock_i;
  fsq_sequencer #(.READ_TICKS(16'h0001), .PROG_TICKS(16'h0002),
    .ERASE_TICKS(16'h0003)) dut (.clock_i(clock_i), .reset_n_i(reset_n_i),
    .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr),
    .reg_rd_i(reg_rd), .reg_rdata_o(rdata), .cpu_in_boot_i(in_boot),
    .boot_zone_pages_i(4'h2), .low_bound_opt_i(8'h80), .cpu_hold_o(hold),
    .flash_addr_o(f_addr), .flash_wdata_o(f_wdata), .flash_rdata_i(f_rdata),
    .flash_read_o(f_read), .flash_prog_o(f_prog), .flash_erase_o(f_erase));
  fsq_flash_model flash (.clock_i(clock_i), .addr_i(f_addr),
    .wdata_i(f_wdata), .read_i(f_read), .prog_i(f_prog), .erase_i(f_erase),
    .rdata_o(f_rdata), .ops_o(ops));
  task automatic final_report;
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : final_report
  task automatic wr(input fsq_idx_t a, input fsq_byte_t v);
    @(posedge clock_i);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clock_i);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic cmp(input string s, input fsq_byte_t e, input fsq_byte_t g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", s, e, g);
    end
  endtask : cmp
  task automatic chk(input fsq_idx_t a, input string s, input fsq_byte_t e);
    @(posedge clock_i);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock_i);
    reg_rd <= 1'b0;
    #1;
    cmp(s, e, rdata);
  endtask : chk
  task automatic fire(output int n);
    wr(`FSQ_OFS_CMD, `FSQ_KEY_FIRST);
    wr(`FSQ_OFS_CMD, `FSQ_KEY_SECOND);
    n = 0;
    #1;
    while (hold === 1'b1 && n < 500) begin
      @(posedge clock_i);
      #1;
      n++;
    end
  endtask : fire
  task automatic op(input fsq_byte_t m, input fsq_addr_t a,
    input fsq_byte_t v, output int n);
    wr(`FSQ_OFS_MODE, m);
    wr(`FSQ_OFS_ADDR_HIGH, a[15:8]);
    wr(`FSQ_OFS_ADDR_LOW, a[7:0]);
    wr(`FSQ_OFS_DATA, v);
    fire(n);
  endtask : op
  task automatic fread(input fsq_addr_t a, input fsq_byte_t e);
    int n;
    op(`FSQ_MODE_READ, a, 8'h00, n);
    chk(`FSQ_OFS_DATA, "flash byte", e);
  endtask : fread
  task automatic refuse(input fsq_byte_t m, input fsq_addr_t a);
    int n;
    fsq_byte_t o;
    o = ops;
    op(m, a, 8'h5e, n);
    cmp("refused hold", 8'h00, 8'(n));
    chk(`FSQ_OFS_STATUS, "ignored flag", 8'h02);
    chk(`FSQ_OFS_DATA, "data kept", 8'h5e);
    cmp("flash ops", o, ops);
    wr(`FSQ_OFS_STATUS, 8'h02);
    chk(`FSQ_OFS_STATUS, "flag cleared", 8'h00);
  endtask : refuse
  task automatic endt(input string s);
    $display("test %s done", s);
  endtask : endt
  initial begin
    repeat (20000) @(posedge clock_i);
    errors++;
    final_report();
  end
  initial begin
    repeat (16) @(posedge clock_i);
    reset_n_i <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      chk(3'(i), "reset value", i == 6 ? 8'h80 : 8'h00);
    end
    wr(`FSQ_OFS_CTRL, 8'hff);
    chk(`FSQ_OFS_CTRL, "control", 8'hbf);
    wr(`FSQ_OFS_CTRL, 8'h80);
    endt("registers");
    op(`FSQ_MODE_ERASE, 16'h8200, 8'h00, n0);
    cmp("erase held", 8'h01, 8'(n0 > 0));
    fread(16'h83ff, 8'hff);
    fread(16'h8400, 8'ha5);
    fread(16'h81ff, 8'ha5);
    op(`FSQ_MODE_PROG, 16'h8205, 8'h3c, n0);
    op(`FSQ_MODE_PROG, 16'h8205, 8'hf0, n0);
    fread(16'h8205, 8'h30);
    endt("erase program");
    wr(`FSQ_OFS_CTRL, 8'h83);
    op(`FSQ_MODE_ERASE, 16'h8400, 8'h00, n3);
    wr(`FSQ_OFS_CTRL, 8'h80);
    cmp("tick scale", 8'h01, 8'(n3 > n0));
    fread(16'h8400, 8'hff);
    endt("timing");
    n0 = ops;
    wr(`FSQ_OFS_CMD, `FSQ_KEY_FIRST);
    chk(`FSQ_OFS_STATUS, "armed", 8'h04);
    wr(`FSQ_OFS_CMD, 8'h00);
    wr(`FSQ_OFS_CMD, `FSQ_KEY_SECOND);
    chk(`FSQ_OFS_STATUS, "not armed", 8'h00);
    cmp("flash ops", 8'(n0), ops);
    endt("key");
    refuse(`FSQ_MODE_PROG, 16'h7f00);
    refuse(`FSQ_MODE_READ, 16'hfc00);
    refuse(`FSQ_MODE_STANDBY, 16'h8205);
    refuse(8'h04, 16'h8205);
    wr(`FSQ_OFS_CTRL, 8'h00);
    refuse(`FSQ_MODE_READ, 16'h8205);
    wr(`FSQ_OFS_CTRL, 8'h80);
    fread(16'hfbff, 8'ha5);
    endt("refusals");
    @(posedge clock_i);
    in_boot <= 1'b1;
    op(`FSQ_MODE_PROG, 16'h1000, 8'h0f, n0);
    fread(16'h1000, 8'h05);
    @(posedge clock_i);
    in_boot <= 1'b0;
    wr(`FSQ_OFS_LOW_BOUND, 8'h81);
    refuse(`FSQ_MODE_ERASE, 16'h8100);
    wr(`FSQ_OFS_LOW_BOUND, 8'h70);
    op(`FSQ_MODE_PROG, 16'h7000, 8'h11, n0);
    fread(16'h7000, 8'h01);
    endt("zones");
    final_report();
  end
endmodule : fsq_sequencer_tb_top
